// >>> rtl/gpio_map.vh
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// ********************************************
// Register offsets
// ********************************************
`define ADDR_W          4
`define OFF_DIRECTION   4'h0
`define OFF_PIN_VALUE   4'h1
`define OFF_OUT_LATCH   4'h2
`define OFF_ANALOG_CFG  4'h3
`define OFF_BIT_SET     4'h4
`define OFF_BIT_CLEAR   4'h5

// ********************************************
// Widths and reset values
// ********************************************
`define PORT_W          16
`define DIR_RESET       16'hFFFF
`define LATCH_RESET     16'h0000
`define ANALOG_RESET    16'h0000
`define IMPL_MASK_DEF   16'hFFFF
`define ANALOG_MASK_DEF 16'h0000

`endif

// >>> rtl/pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// ********************************************
// Two-stage synchroniser for pin levels
// ********************************************
module pin_sync #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] raw,
    output reg  [WIDTH-1:0] synced
);
    reg [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always @(posedge clk) begin
        if (!rst_b) begin
            stage1 <= {WIDTH{1'b0}};
            synced <= {WIDTH{1'b0}};
        end else begin
            stage1 <= raw;
            synced <= stage1;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/pin_mux.v
`timescale 1ns/10ps
`default_nettype none

// ********************************************
// Per-pin output ownership multiplexers
// ********************************************
module pin_mux (
    input  wire port_data,
    input  wire port_dir,
    input  wire periph_en,
    input  wire periph_data,
    input  wire periph_oe,
    input  wire implemented,
    input  wire digital_ok,
    output wire pin_out,
    output wire pin_oe
);
    // Peripheral wins data, and enable on implemented pins, once enabled
    // peripheral data wins
    assign pin_out = periph_en ? periph_data : port_data;
    // Direction 0 drives; 1 is input; absent pins never drive; unconfigured analog pins drive only when a peripheral owns them
    // enable owner select
    assign pin_oe  = implemented & (periph_en ? periph_oe : (~port_dir & digital_ok));
endmodule

`default_nettype wire

// >>> rtl/gpio_port.v
// Operation
// - Direction 1 makes pin input, driver off
// - Direction 0 drives latch unless peripheral owns
// - Reset sets all directions to input
// - Pin register read returns pin level
// - Pin register write stores into latch
// - Latch register read returns latch contents
// - Latch register write equals pin write
// - Unimplemented bits read zero everywhere
// - One bit per pin, matching positions
// - Bit set/clear reads pins, writes latch
// - Enabled peripheral always takes an implemented pin
// - Multiplexers choose data and enable owner
// - Port driver off while peripheral owns
// - Owned pin still readable through port, except unconfigured analog-shared pins read zero
// - Analog-shared pins digital only when configured, except that an owning peripheral drives them
// - Owned pins ignore port and direction
`timescale 1ns/10ps
`default_nettype none
`include "gpio_map.vh"

module gpio_port #(
    parameter WIDTH       = `PORT_W,
    parameter IMPL_MASK   = `IMPL_MASK_DEF,
    parameter ANALOG_MASK = `ANALOG_MASK_DEF
) (
    input  wire               clk,
    input  wire               rst_b,
    input  wire [`ADDR_W-1:0] addr,
    input  wire [WIDTH-1:0]   wdata,
    input  wire               wr,
    input  wire               rd,
    output reg  [WIDTH-1:0]   rdata,
    input  wire [WIDTH-1:0]   pin_in,
    output wire [WIDTH-1:0]   pin_out,
    output wire [WIDTH-1:0]   pin_oe,
    input  wire [WIDTH-1:0]   periph_en,
    input  wire [WIDTH-1:0]   periph_out,
    input  wire [WIDTH-1:0]   periph_oe
);
    localparam [WIDTH-1:0] IMPL   = IMPL_MASK[WIDTH-1:0];
    localparam [WIDTH-1:0] ANALOG = ANALOG_MASK[WIDTH-1:0];

    // ********************************************
    // Storage
    // ********************************************
    reg  [WIDTH-1:0] direction;
    reg  [WIDTH-1:0] out_latch;
    reg  [WIDTH-1:0] analog_cfg;
    reg  [WIDTH-1:0] next_latch;
    wire [WIDTH-1:0] pin_level;
    wire [WIDTH-1:0] digital_ok;
    wire [WIDTH-1:0] pin_view;

    // ********************************************
    // Pin input path
    // ********************************************
    // Pins are asynchronous to clk; settle before software sees them
    pin_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk    (clk),
        .rst_b  (rst_b),
        .raw    (pin_in),
        .synced (pin_level)
    );

    assign digital_ok = ~ANALOG | analog_cfg;
    // owned pins readable unless analog-shared and unconfigured; absent bits zero
    assign pin_view   = pin_level & digital_ok & IMPL;

    // ********************************************
    // Latch update
    // ********************************************
    // Bit set/clear builds on live pin levels, so input pins leak into latch
    always @* begin
        next_latch = out_latch;
        if (wr) begin
            case (addr)
                `OFF_PIN_VALUE: next_latch = wdata;
                `OFF_OUT_LATCH: next_latch = wdata;
                `OFF_BIT_SET:   next_latch = pin_view | wdata;
                `OFF_BIT_CLEAR: next_latch = pin_view & ~wdata;
                default:        next_latch = out_latch;
            endcase
        end
    end

    // ********************************************
    // Registers
    // ********************************************
    // Unimplemented bits are masked at write so they stay zero
    always @(posedge clk) begin
        if (!rst_b) begin
            direction  <= `DIR_RESET & IMPL;
            out_latch  <= `LATCH_RESET;
            analog_cfg <= `ANALOG_RESET;
        end else begin
            out_latch <= next_latch & IMPL;
            if (wr && addr == `OFF_DIRECTION) begin
                direction <= wdata & IMPL;
            end
            if (wr && addr == `OFF_ANALOG_CFG) begin
                analog_cfg <= wdata & ANALOG;
            end
        end
    end

    // ********************************************
    // Read port
    // ********************************************
    // Data only in the cycle after the strobe; zero otherwise
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= {WIDTH{1'b0}};
        end else if (rd) begin
            case (addr)
                `OFF_DIRECTION:  rdata <= direction;
                `OFF_PIN_VALUE:  rdata <= pin_view;
                `OFF_OUT_LATCH:  rdata <= out_latch;
                `OFF_ANALOG_CFG: rdata <= analog_cfg;
                default:         rdata <= {WIDTH{1'b0}};
            endcase
        end else begin
            rdata <= {WIDTH{1'b0}};
        end
    end

    // ********************************************
    // Output ownership, one mux pair per pin
    // ********************************************
    // matching bit positions; inside mux
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            pin_mux u_mux (
                .port_data   (out_latch[i]),
                .port_dir    (direction[i]),
                .periph_en   (periph_en[i]),
                .periph_data (periph_out[i]),
                .periph_oe   (periph_oe[i]),
                .implemented (IMPL[i]),
                .digital_ok  (digital_ok[i]),
                .pin_out     (pin_out[i]),
                .pin_oe      (pin_oe[i])
            );
        end
    endgenerate
endmodule

`default_nettype wire

// >>> tb/pin_world.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Pin side
// **********
module pin_world (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] ext_level,
    output wire logic [15:0] pin_in
);
    // Device wins where it drives, outside parts elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// >>> tb/gpio_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Port checker
// **********
module gpio_monitor #(parameter IMPL_MASK = 16'hFFFF, ANALOG_MASK = 16'h0000) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] periph_en,
    input wire logic [15:0] periph_out,
    input wire logic [15:0] periph_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Latch write, one idle cycle, latch read
    sequence wr_then_rd;
        wr && addr == 4'h2 ##1 !wr ##1 rd && addr == 4'h2;
    endsequence
    owned_oe_a: assert property (((pin_oe ^ periph_oe) & periph_en & IMPL_MASK) == 16'h0000)
        else $error("owned enable");
    owned_data_a: assert property (((pin_out ^ periph_out) & periph_en) == 16'h0000)
        else $error("owned data");
    read_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("idle rdata");
    reset_input_a: assert property ($rose(rst_b) |-> (pin_oe & ~periph_en) == 16'h0000)
        else $error("reset drive");
    dir_oe_a: assert property (wr && addr == 4'h0 |=> ((pin_oe ^ ~$past(wdata))
        & ~periph_en & IMPL_MASK & ~ANALOG_MASK) == 16'h0000) else $error("direction");
    latch_out_a: assert property (wr && (addr == 4'h1 || addr == 4'h2) |=>
        ((pin_out ^ $past(wdata)) & pin_oe & ~periph_en) == 16'h0000) else $error("pin data");
    latch_read_a: assert property (wr_then_rd |=> rdata == ($past(wdata, 3) & IMPL_MASK))
        else $error("latch read");
    unimpl_off_a: assert property ((pin_oe & ~IMPL_MASK & ~periph_en) == 16'h0000)
        else $error("unimpl drive");
endmodule
bind gpio_port gpio_monitor #(.IMPL_MASK(IMPL_MASK), .ANALOG_MASK(ANALOG_MASK)) port_mon (
    .clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .pin_out, .pin_oe, .periph_en,
    .periph_out, .periph_oe);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Port bench
// **********
module testbench;
    logic        clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, ext = 16'h0000, pen = 16'h0000, pout = 16'h0000;
    logic [15:0] poe = 16'h0000;
    wire  [15:0] rdata, pin_in, pin_out, pin_oe;
    int          n_errors = 0, check_count = 0, cycles = 0;
    // Bit 15 unimplemented, bits 4..7 analog-shared
    gpio_port #(.IMPL_MASK(16'h7FFF), .ANALOG_MASK(16'h00F0)) DUT (.clk, .rst_b, .addr,
        .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe, .periph_en(pen),
        .periph_out(pout), .periph_oe(poe));
    pin_world world (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
    initial forever #25 clk = ~clk;
    // Hang guard, run needs about 65 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            report_and_stop;
        end
    end
    task report_and_stop;
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input string n, input logic [15:0] e, s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rchk(input string n, input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        cmp(n, e, rdata);
    endtask
    task t_reset(input logic [15:0] e_oe);
        rchk("direction", 4'h0, 16'h7FFF);
        rchk("latch", 4'h2, 16'h0000);
        rchk("unmapped", 4'h9, 16'h0000);
        rchk("bit_set", 4'h4, 16'h0000);
        cmp("pin_oe", e_oe, pin_oe);
    endtask
    task t_output;
        wreg(4'h1, 16'hA5A5);
        wreg(4'h0, 16'h0000);
        // Look once the direction write has settled
        @(negedge clk);
        cmp("pin_oe", 16'h7F0F, pin_oe);
        cmp("pin_out", 16'h2505, pin_out & 16'h7F0F);
        rchk("latch", 4'h2, 16'h25A5);
        rchk("pins", 4'h1, 16'h2505);
        wreg(4'h2, 16'h0FF0);
        rchk("latch", 4'h2, 16'h0FF0);
    endtask
    task t_input;
        wreg(4'h0, 16'hFFFF);
        ext <= 16'h1234;
        // Give the synchroniser time for the new level
        @(posedge clk);
        rchk("pins", 4'h1, 16'h1204);
        cmp("pin_oe", 16'h0000, pin_oe);
        wreg(4'h3, 16'hFFFF);
        rchk("analog", 4'h3, 16'h00F0);
        rchk("pins", 4'h1, 16'h1234);
        wreg(4'h4, 16'h0001);
        rchk("latch", 4'h2, 16'h1235);
        wreg(4'h5, 16'h0014);
        rchk("latch", 4'h2, 16'h1220);
    endtask
    task t_periph;
        wreg(4'h0, 16'h0000);
        pen <= 16'h00FF;
        pout <= 16'h00AA;
        poe <= 16'h000F;
        // Owned pin levels need two edges to reach the read path
        @(posedge clk);
        rchk("pins", 4'h1, 16'h123A);
        cmp("pin_oe", 16'h7F0F, pin_oe);
        cmp("pin_out", 16'h00AA, pin_out & 16'h00FF);
    endtask
    // Main sequence, second reset with a peripheral still owning pins
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        t_reset(16'h0000);
        t_output;
        t_input;
        t_periph;
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        t_reset(16'h000F);
        report_and_stop;
    end
endmodule
`default_nettype wire
